// ### rtl/lf_wakeup_defines.svh
`ifndef LF_WAKEUP_DEFINES_SVH
`define LF_WAKEUP_DEFINES_SVH

// register byte addresses on the apb bus
`define OFS_FEATURE_ENABLE   12'h000
`define OFS_DETECT_TOLERANCE 12'h004
`define OFS_SLICER_ENVELOPE  12'h008
`define OFS_PATTERN_A        12'h00C
`define OFS_PATTERN_B        12'h010
`define OFS_BIT_RATE_TIMEOUT 12'h014
`define OFS_FALSE_WAKEUP     12'h018
`define OFS_COMMAND          12'h01C
`define OFS_STATUS           12'h020

// feature_enable_reg fields
`define FE_CORR_EN    1
`define FE_DOUBLE     2
`define FE_MANCH_EN   3
`define FE_ABS_THR    7
// detect_tolerance_reg fields
`define DT_TOL_LO     5
`define DT_TOL_HI     6
`define DT_ABS_LOW    7
// bit_rate_timeout_config fields
`define BR_RATE_HI    4
`define BR_TOUT_LO    5
`define BR_TOUT_HI    7
// command register bits, write one to fire
`define CMD_CLEAR_WAKE  0
`define CMD_CLEAR_FALSE 1

// reset values
`define RST_FEATURE_ENABLE   8'h00
`define RST_DETECT_TOLERANCE 8'h00
`define RST_SLICER_ENVELOPE  8'h00
`define RST_PATTERN          8'h96
`define RST_BIT_RATE_TIMEOUT 8'h03

// correlator timing, in bits
`define PREAMBLE_WAIT_BITS   16
`define PREAMBLE_MIN_BITS    4
`define PREAMBLE_PATTERN_MAX 40
`define PATTERN_HALF_BITS    16
`define MIN_BIT_CODE         5'h03

// wake timeout step
`define PCLK_HZ              25000000
`define TIMEOUT_STEP_MS      50
`define TIMEOUT_STEP_CYCLES  ((`TIMEOUT_STEP_MS * `PCLK_HZ) / 1000)

`endif

// ### rtl/lf_wakeup_pkg.sv
package lf_wakeup_pkg;

    typedef enum logic [4:0] {
        ST_LISTEN   = 5'h01,
        ST_PREAMBLE = 5'h02,
        ST_PATTERN  = 5'h04,
        ST_WAKE     = 5'h08,
        ST_FAIL     = 5'h10
    } corr_state_e;

    // analog slicer / envelope settings, passed out; envelope rate forced to zero under absolute threshold
    typedef struct packed {
        logic       abs_thr_en;
        logic       abs_thr_low;
        logic       thr_40mv;
        logic       symmetric;
        logic [2:0] preamble_sel;
        logic [2:0] env_rate_sel;
    } slicer_ctrl_s;

    typedef struct packed {
        logic data;
        logic clock;
    } decode_out_s;

endpackage : lf_wakeup_pkg

// ### rtl/lf_wakeup_pattern_correlator.sv
// Register access over APB and the address map were decided locally.
`include "lf_wakeup_defines.svh"
// What this block does
// - correlate only when correlator enable set; otherwise wake on carrier alone
// - wait up to 16 bits for preamble; else listen again and count false wakeup
// - pattern search starts only after four preamble bits seen
// - bit duration is bit-rate code plus one rtc periods, 4 to 32
// - pattern is two programmable bytes, compared as 16 half bits
// - manchester low-to-high means zero, high-to-low means one
// - pattern is sent and compared msb first
// - pattern bytes reset to hex 96
// - config bit selects single or double pattern; double needs two in a row
// - two-bit tolerance allows zero to three missed zeros
// - successful match raises wake output
// - with decoder enabled, output decoded data and recovered clock
// - decoded data stable at recovered clock rising edge
// - failed detection ends internal wakeup silently and counts false wakeup
// - host clear-wake command ends the wake state
// - three-bit timeout field, 50 ms per step, 50 to 350 ms; code zero never times out
// - three-bit envelope field selects symbol rate 4096 down to 512
// - bits select positive or symmetric threshold and 20 or 40 mV
// - absolute threshold enable overrides envelope rate; another bit lowers it
// - timeout counts from wake rising edge, then back to listening
// - clear-wake returns to listening; clear-false zeroes false counter
module lf_wakeup_pattern_correlator
    import lf_wakeup_pkg::*;
#(
    parameter int unsigned TIMEOUT_STEP_CYCLES = `TIMEOUT_STEP_CYCLES,
    parameter int unsigned PATTERN_HALF_BITS   = `PATTERN_HALF_BITS
) (
    input  wire logic         pclk,             // bus clock, 25 MHz
    input  wire logic         presetn,          // async reset, active low
    input  wire logic         psel,             // apb select
    input  wire logic         penable,          // apb access phase
    input  wire logic         pwrite,           // apb direction
    input  wire logic [11:0]  paddr,            // apb byte address
    input  wire logic [31:0]  pwdata,           // apb write data
    output logic      [31:0]  prdata,           // apb read data
    output logic              pready,           // apb ready
    output logic              pslverr,          // apb error on unmapped address
    input  wire logic         rtc_clk_in,       // real-time clock pin
    input  wire logic         carrier_det_in,   // carrier frequency detected
    input  wire logic         envelope_in,      // sliced envelope, carrier on high
    output logic              wake_out,         // wake toward host
    output decode_out_s       decode_out,       // decoded data and recovered clock
    output slicer_ctrl_s      slicer_ctrl_out   // analog slicer settings
);

    localparam int HW = PATTERN_HALF_BITS;

    logic [7:0]  feature_enable_reg;
    logic [7:0]  detect_tolerance_reg;
    logic [7:0]  slicer_envelope_config;
    logic [7:0]  wake_pattern_byte_a;
    logic [7:0]  wake_pattern_byte_b;
    logic [7:0]  bit_rate_timeout_config;
    logic [7:0]  false_wakeup_counter;
    corr_state_e state_reg, state_next;

    // ---------------- pin synchronisers ----------------
    logic [2:0] rtc_sync, car_sync, env_sync;
    logic       rtc_filt, car_filt, env_filt, rtc_prev, car_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_sync <= 3'h0;
            car_sync <= 3'h0;
            env_sync <= 3'h0;
        end else begin
            rtc_sync <= {rtc_sync[1:0], rtc_clk_in};
            car_sync <= {car_sync[1:0], carrier_det_in};
            env_sync <= {env_sync[1:0], envelope_in};
        end
    end

    // a change only counts once the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_filt <= 1'b0;
            car_filt <= 1'b0;
            env_filt <= 1'b0;
            rtc_prev <= 1'b0;
            car_prev <= 1'b0;
        end else begin
            if (rtc_sync[1] == rtc_sync[2]) rtc_filt <= rtc_sync[2];
            if (car_sync[1] == car_sync[2]) car_filt <= car_sync[2];
            if (env_sync[1] == env_sync[2]) env_filt <= env_sync[2];
            rtc_prev <= rtc_filt;
            car_prev <= car_filt;
        end
    end

    wire rtc_tick = rtc_filt & ~rtc_prev;
    wire car_rise = car_filt & ~car_prev;

    // ---------------- apb slave ----------------
    wire        setup_ph  = psel & ~penable;
    wire        access_ok = psel & penable & pready;
    wire        wr_en     = access_ok & pwrite;
    logic       mapped;
    logic [7:0] rd_mux;
    logic       cmd_clear_wake, cmd_clear_false;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 8'h00;
        unique case (paddr)
            `OFS_FEATURE_ENABLE:   rd_mux = feature_enable_reg;
            `OFS_DETECT_TOLERANCE: rd_mux = detect_tolerance_reg;
            `OFS_SLICER_ENVELOPE:  rd_mux = slicer_envelope_config;
            `OFS_PATTERN_A:        rd_mux = wake_pattern_byte_a;
            `OFS_PATTERN_B:        rd_mux = wake_pattern_byte_b;
            `OFS_BIT_RATE_TIMEOUT: rd_mux = bit_rate_timeout_config;
            `OFS_FALSE_WAKEUP:     rd_mux = false_wakeup_counter;
            `OFS_COMMAND:          rd_mux = 8'h00;
            `OFS_STATUS:           rd_mux = {2'h0, state_reg, wake_out};
            default:               mapped = 1'b0;
        endcase
    end

    // zero wait states: ready is raised in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            if (setup_ph) prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feature_enable_reg      <= `RST_FEATURE_ENABLE;
            detect_tolerance_reg    <= `RST_DETECT_TOLERANCE;
            slicer_envelope_config  <= `RST_SLICER_ENVELOPE;
            wake_pattern_byte_a     <= `RST_PATTERN;
            wake_pattern_byte_b     <= `RST_PATTERN;
            bit_rate_timeout_config <= `RST_BIT_RATE_TIMEOUT;
        end else if (wr_en) begin
            unique case (paddr)
                `OFS_FEATURE_ENABLE:   feature_enable_reg      <= pwdata[7:0];
                `OFS_DETECT_TOLERANCE: detect_tolerance_reg    <= pwdata[7:0];
                `OFS_SLICER_ENVELOPE:  slicer_envelope_config  <= pwdata[7:0];
                `OFS_PATTERN_A:        wake_pattern_byte_a     <= pwdata[7:0];
                `OFS_PATTERN_B:        wake_pattern_byte_b     <= pwdata[7:0];
                `OFS_BIT_RATE_TIMEOUT: bit_rate_timeout_config <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    assign cmd_clear_wake  = wr_en && paddr == `OFS_COMMAND && pwdata[`CMD_CLEAR_WAKE];
    assign cmd_clear_false = wr_en && paddr == `OFS_COMMAND && pwdata[`CMD_CLEAR_FALSE];

    // analog settings leave as a registered copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slicer_ctrl_out <= '0;
        end else begin
            slicer_ctrl_out.abs_thr_en   <= feature_enable_reg[`FE_ABS_THR];
            slicer_ctrl_out.abs_thr_low  <= detect_tolerance_reg[`DT_ABS_LOW];
            slicer_ctrl_out.thr_40mv     <= slicer_envelope_config[7];
            slicer_ctrl_out.symmetric    <= slicer_envelope_config[6];
            slicer_ctrl_out.preamble_sel <= slicer_envelope_config[5:3];
            // envelope rate is meaningless under absolute threshold
            slicer_ctrl_out.env_rate_sel <= feature_enable_reg[`FE_ABS_THR] ?
                                            3'h0 : slicer_envelope_config[2:0];
        end
    end

    // ---------------- half-bit timing ----------------
    // accumulate two per rtc tick against the bit length so odd lengths split evenly
    logic [4:0] rate_code;
    logic [5:0] bit_len;
    logic [6:0] half_acc;
    logic       half_tick, half_ph;
    wire        in_corr = (state_reg == ST_PREAMBLE) || (state_reg == ST_PATTERN) ||
                          (state_reg == ST_WAKE);

    always_comb begin
        rate_code = bit_rate_timeout_config[`BR_RATE_HI:0];
        if (rate_code < `MIN_BIT_CODE) rate_code = `MIN_BIT_CODE;
        bit_len = {1'b0, rate_code} + 6'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_acc  <= 7'h00;
            half_tick <= 1'b0;
            half_ph   <= 1'b0;
        end else if (!in_corr || car_rise) begin
            half_acc  <= 7'h00;
            half_tick <= 1'b0;
            half_ph   <= 1'b0;
        end else begin
            half_tick <= 1'b0;
            if (rtc_tick) begin
                if (half_acc + 7'h02 >= {1'b0, bit_len}) begin
                    half_acc  <= half_acc + 7'h02 - {1'b0, bit_len};
                    half_tick <= 1'b1;
                    half_ph   <= ~half_ph;
                end else begin
                    half_acc <= half_acc + 7'h02;
                end
            end
        end
    end

    // a bit ends when the second half closes
    wire bit_tick = half_tick & ~half_ph;

    // ---------------- correlation ----------------
    logic [HW-1:0] half_shift;
    logic [HW-1:0] pattern;
    logic [HW-1:0] miss_zero, bad_one;
    logic [4:0]    miss_cnt;
    logic [1:0]    tol;
    logic          match;
    logic          first_half, prev_bit, prev_valid;
    logic [2:0]    alt_cnt;
    logic [5:0]    bit_cnt;
    logic [4:0]    gap_cnt;
    logic          first_hit;

    assign pattern = {wake_pattern_byte_a, wake_pattern_byte_b};
    assign tol     = detect_tolerance_reg[`DT_TOL_HI:`DT_TOL_LO];

    // newest half bit enters at lsb, so the first sent lines up with the msb
    genvar gi;
    generate
        for (gi = 0; gi < HW; gi++) begin : g_cmp
            assign miss_zero[gi] = ~pattern[gi] & half_shift[gi];
            assign bad_one[gi]   = pattern[gi] & ~half_shift[gi];
        end
    endgenerate

    always_comb begin
        miss_cnt = 5'h00;
        for (int i = 0; i < HW; i++) miss_cnt = miss_cnt + {4'h0, miss_zero[i]};
        match = (bad_one == '0) && (miss_cnt <= {3'h0, tol});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_shift <= '0;
        end else if (state_reg != ST_PATTERN) begin
            half_shift <= '0;
        end else if (half_tick) begin
            half_shift <= {half_shift[HW-2:0], env_filt};
        end
    end

    // preamble: each bit is carrier on or off; count alternations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_half <= 1'b0;
            prev_bit   <= 1'b0;
            prev_valid <= 1'b0;
            alt_cnt    <= 3'h0;
            bit_cnt    <= 6'h00;
        end else if (state_reg == ST_LISTEN || state_reg == ST_FAIL) begin
            prev_valid <= 1'b0;
            alt_cnt    <= 3'h0;
            bit_cnt    <= 6'h00;
        end else begin
            if (half_tick && !half_ph) first_half <= env_filt;
            if (bit_tick) begin
                bit_cnt    <= bit_cnt + 6'h01;
                prev_bit   <= first_half;
                prev_valid <= 1'b1;
                if (state_reg == ST_PREAMBLE) begin
                    if (prev_valid && first_half != prev_bit) begin
                        if (alt_cnt != 3'h7) alt_cnt <= alt_cnt + 3'h1;
                    end else begin
                        alt_cnt <= 3'h0;
                    end
                end
            end
        end
    end

    // double mode: the repeat must close exactly one pattern length later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_hit <= 1'b0;
            gap_cnt   <= 5'h00;
        end else if (state_reg != ST_PATTERN) begin
            first_hit <= 1'b0;
            gap_cnt   <= 5'h00;
        end else if (half_tick) begin
            if (!first_hit && match) begin
                first_hit <= 1'b1;
                gap_cnt   <= 5'h00;
            end else if (first_hit) begin
                gap_cnt <= gap_cnt + 5'h01;
            end
        end
    end

    // one alternation short of the bits: the first bit has nothing to compare with
    wire pre_done   = alt_cnt >= 3'(`PREAMBLE_MIN_BITS - 1);
    wire pre_expire = bit_tick && bit_cnt == 6'(`PREAMBLE_WAIT_BITS - 1);
    wire len_expire = bit_tick && bit_cnt == 6'(`PREAMBLE_PATTERN_MAX - 1);
    wire dbl_mode   = feature_enable_reg[`FE_DOUBLE];
    wire gap_full   = gap_cnt == 5'(HW - 1);
    wire pat_hit    = half_tick && match && (!dbl_mode || (first_hit && gap_full));
    wire dbl_broken = half_tick && first_hit && gap_full && !match;
    logic timeout_hit;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_LISTEN: begin
                if (car_rise)
                    state_next = feature_enable_reg[`FE_CORR_EN] ? ST_PREAMBLE : ST_WAKE;
            end
            ST_PREAMBLE: begin
                if (pre_done && bit_tick) state_next = ST_PATTERN;
                else if (pre_expire)      state_next = ST_FAIL;
            end
            ST_PATTERN: begin
                if (pat_hit)                      state_next = ST_WAKE;
                else if (dbl_broken || len_expire) state_next = ST_FAIL;
            end
            ST_WAKE: begin
                if (cmd_clear_wake || timeout_hit) state_next = ST_LISTEN;
            end
            ST_FAIL: state_next = ST_LISTEN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_reg <= ST_LISTEN;
        else          state_reg <= state_next;
    end

    // wake only follows the state; a failure never touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wake_out <= 1'b0;
        else          wake_out <= (state_next == ST_WAKE);
    end

    // a clear with a simultaneous increment leaves one; stops at all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            false_wakeup_counter <= 8'h00;
        end else if (state_reg == ST_FAIL) begin
            if (cmd_clear_false)                  false_wakeup_counter <= 8'h01;
            else if (false_wakeup_counter != 8'hFF) false_wakeup_counter <= false_wakeup_counter + 8'h01;
        end else if (cmd_clear_false) begin
            false_wakeup_counter <= 8'h00;
        end
    end

    // ---------------- wake timeout ----------------
    localparam int STEP_W = $clog2(TIMEOUT_STEP_CYCLES + 1);
    logic [STEP_W-1:0] step_cnt;
    logic [2:0]        step_num;
    wire  [2:0]        tout_code = bit_rate_timeout_config[`BR_TOUT_HI:`BR_TOUT_LO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt <= '0;
            step_num <= 3'h0;
        end else if (!wake_out) begin
            step_cnt <= '0;
            step_num <= 3'h0;
        end else if (step_cnt == STEP_W'(TIMEOUT_STEP_CYCLES - 1)) begin
            step_cnt <= '0;
            if (step_num != 3'h7) step_num <= step_num + 3'h1;
        end else begin
            step_cnt <= step_cnt + 1'b1;
        end
    end

    // code zero never expires, so only the host can end wake
    assign timeout_hit = (tout_code != 3'h0) && (step_num == tout_code);

    // ---------------- manchester decode ----------------
    // symbol known only when a bit closes, so it is shown one bit late
    logic decode_armed;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decode_out   <= '0;
            decode_armed <= 1'b0;
        end else if (state_reg != ST_WAKE || !feature_enable_reg[`FE_MANCH_EN]) begin
            decode_out   <= '0;
            decode_armed <= 1'b0;
        end else if (bit_tick) begin
            decode_out.data  <= first_half;
            decode_out.clock <= 1'b0;
            decode_armed     <= 1'b1;
        end else if (half_tick && decode_armed) begin
            decode_out.clock <= 1'b1;
        end
    end

endmodule : lf_wakeup_pattern_correlator

// ### tb/lf_tx_model.sv
module lf_tx_model (
    input  wire logic pclk,     // timing base
    output logic      rtc,      // free-running rtc
    output logic      carrier,  // carrier detect
    output logic      envelope  // sliced envelope
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] tick_cnt = 4'h0;
    initial begin
        carrier = 1'b0;
        envelope = 1'b0;
    end
    // one rtc tick per 16 pclk, far below the bus clock
    always_ff @(posedge pclk) begin
        tick_cnt <= tick_cnt + 4'h1;
    end
    assign rtc = tick_cnt[3];
    task automatic hold(input logic env, input int ticks);
        envelope <= env;
        repeat (ticks * 16) @(posedge pclk);
    endtask : hold
    task automatic start();
        do @(posedge pclk); while (tick_cnt != 4'h7);
        carrier <= 1'b1;
    endtask : start
    task automatic send(input logic [15:0] pat, input int pre, input int copies);
        start();
        // envelope edges sit mid rtc tick so the half-bit sample never races them
        repeat (8) @(posedge pclk);
        for (int b = 0; b < pre; b++)
            hold(~b[0], 4);
        for (int c = 0; c < copies; c++)
            for (int h = 15; h >= 0; h--)
                hold(pat[h], 2);
        carrier <= 1'b0;
        envelope <= 1'b0;
    endtask : send
    task automatic burst(input int bits);
        start();
        hold(1'b1, bits * 4);
        carrier <= 1'b0;
        envelope <= 1'b0;
    endtask : burst
endmodule : lf_tx_model

// ### tb/lf_wakeup_monitor.sv
module lf_wakeup_monitor
    import lf_wakeup_pkg::*;
#(
    parameter int unsigned TIMEOUT_STEP_CYCLES = 20,
    parameter int unsigned PATTERN_HALF_BITS   = 16
) (
    input wire logic         pclk,            // clock
    input wire logic         presetn,         // reset
    input wire logic         psel,            // select
    input wire logic         penable,         // access
    input wire logic         pwrite,          // direction
    input wire logic [11:0]  paddr,           // address
    input wire logic [31:0]  pwdata,          // write data
    input wire logic [31:0]  prdata,          // read data
    input wire logic         pready,          // ready
    input wire logic         pslverr,         // error
    input wire logic         wake_out,        // wake
    input wire decode_out_s  decode_out,      // decoder
    input wire slicer_ctrl_s slicer_ctrl_out  // slicer
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence clear_wake_s;
        psel && penable && pready && pwrite && paddr == 12'h01C && pwdata[0];
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
    unmapped_err_a: assert property (psel && !penable && paddr > 12'h020 |=> pslverr) else $error("no error");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper bits");
    clear_wake_a: assert property (clear_wake_s |=> ##1 !wake_out) else $error("wake kept");
    // decoder output lags the state by one cycle, so look once wake has been low for three
    decode_idle_a: assert property (!wake_out [*3] |-> decode_out == 2'b00)
        else $error("decoder active");
    abs_rate_a: assert property (slicer_ctrl_out.abs_thr_en |-> slicer_ctrl_out.env_rate_sel == 3'h0)
        else $error("rate not forced");
endmodule : lf_wakeup_monitor

bind lf_wakeup_pattern_correlator lf_wakeup_monitor #(
    .TIMEOUT_STEP_CYCLES(TIMEOUT_STEP_CYCLES), .PATTERN_HALF_BITS(PATTERN_HALF_BITS)
) i_lf_wakeup_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_out(wake_out),
    .decode_out(decode_out), .slicer_ctrl_out(slicer_ctrl_out)
);

// ### tb/lf_wakeup_pattern_correlator_tb.sv
module lf_wakeup_pattern_correlator_tb import lf_wakeup_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, er, rtc, carrier, envelope, wake_out;
    decode_out_s  decode_out;
    slicer_ctrl_s slicer_ctrl_out;
    int           failures = 0;
    int           checks_done = 0;
    initial forever #20 pclk = ~pclk;
    lf_tx_model i_lf_tx_model (.pclk(pclk), .rtc(rtc), .carrier(carrier), .envelope(envelope));
    // short timeout step keeps the run small
    lf_wakeup_pattern_correlator #(.TIMEOUT_STEP_CYCLES(200), .PATTERN_HALF_BITS(16)) i_lf_wakeup_pattern_correlator (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_clk_in(rtc),
        .carrier_det_in(carrier), .envelope_in(envelope), .wake_out(wake_out), .decode_out(decode_out),
        .slicer_ctrl_out(slicer_ctrl_out));
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic ran_out();
        failures++;
        $display("BAD %0t wait ran out", $time);
        give_verdict();
    endtask : ran_out
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 16)
            ran_out();
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc
    task automatic wait_wake(input logic lvl, input int lim);
        int n;
        n = 0;
        while (wake_out !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n == lim)
            ran_out();
    endtask : wait_wake
    task automatic t_registers();
        rdc(12'h00C, 32'h96);
        rdc(12'h010, 32'h96);
        rdc(12'h014, 32'h03);
        apb(1'b0, 12'h024, 32'h0);
        check(er, 1'b1);
        wr(12'h008, 32'hC5);
        rdc(12'h008, 32'hC5);
        check(slicer_ctrl_out, 10'h0C5);
        wr(12'h000, 32'h80);
        wr(12'h004, 32'h80);
        @(posedge pclk);
        check(slicer_ctrl_out, 10'h3C0);
        wr(12'h018, 32'h55);
        rdc(12'h018, 32'h00);
    endtask : t_registers
    task automatic t_carrier_only();
        wr(12'h000, 32'h00);
        wr(12'h004, 32'h00);
        i_lf_tx_model.burst(2);
        wait_wake(1'b1, 200);
        repeat (100) @(posedge pclk);
        check(wake_out, 1'b1);
        wr(12'h01C, 32'h01);
        wait_wake(1'b0, 4);
        check(wake_out, 1'b0);
    endtask : t_carrier_only
    task automatic t_pattern();
        wr(12'h014, 32'h23);
        wr(12'h000, 32'h02);
        i_lf_tx_model.send(16'h9696, 6, 1);
        wait_wake(1'b1, 100);
        repeat (150) @(posedge pclk);
        check(wake_out, 1'b1);
        wait_wake(1'b0, 100);
        check(wake_out, 1'b0);
    endtask : t_pattern
    task automatic t_false();
        i_lf_tx_model.burst(20);
        repeat (8) @(posedge pclk);
        rdc(12'h018, 32'h01);
        i_lf_tx_model.send(16'h9697, 6, 1);
        repeat (2000) @(posedge pclk);
        check(wake_out, 1'b0);
        rdc(12'h018, 32'h02);
        wr(12'h01C, 32'h02);
        rdc(12'h018, 32'h00);
    endtask : t_false
    task automatic t_tol_double();
        int n;
        wr(12'h004, 32'h20);
        i_lf_tx_model.send(16'h9697, 6, 1);
        wait_wake(1'b1, 100);
        check(wake_out, 1'b1);
        wr(12'h01C, 32'h01);
        wr(12'h000, 32'h0E);
        i_lf_tx_model.send(16'h9696, 6, 1);
        repeat (2000) @(posedge pclk);
        check(wake_out, 1'b0);
        i_lf_tx_model.send(16'h9696, 6, 2);
        wait_wake(1'b1, 100);
        check(wake_out, 1'b1);
        n = 0;
        repeat (150) begin
            @(posedge pclk);
            n += decode_out.clock;
        end
        check(n > 0, 1'b1);
    endtask : t_tol_double
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_registers();
        t_carrier_only();
        t_pattern();
        t_false();
        t_tol_double();
        give_verdict();
    end
endmodule : lf_wakeup_pattern_correlator_tb
